//--- rtl/gpport_pkg.sv
// Constants for the GPIO port pin control block
package gpport_pkg;
  localparam int          PIN_W      = 32;
  localparam int          ADDR_W     = 8;
  // Register byte offsets
  localparam logic [7:0]  FSEL0      = 8'h00;
  localparam logic [7:0]  FSEL0_SET  = 8'h04;
  localparam logic [7:0]  FSEL0_CLR  = 8'h08;
  localparam logic [7:0]  DRV_EN     = 8'h0C;
  localparam logic [7:0]  DRV_EN_SET = 8'h10;
  localparam logic [7:0]  DRV_EN_CLR = 8'h14;
  localparam logic [7:0]  OUT_LVL    = 8'h18;
  localparam logic [7:0]  OUT_SET    = 8'h1C;
  localparam logic [7:0]  OUT_CLR    = 8'h20;
  localparam logic [7:0]  IN_LVL     = 8'h24;
  localparam logic [7:0]  IRQ_MODE   = 8'h28;
  localparam logic [7:0]  IRQ_POL    = 8'h2C;
  localparam logic [7:0]  IN_CONN    = 8'h30;
  localparam logic [7:0]  IRQ_EN     = 8'h34;
  localparam logic [7:0]  IRQ_EN_SET = 8'h38;
  localparam logic [7:0]  IRQ_EN_CLR = 8'h3C;
  localparam logic [7:0]  IRQ_PEND   = 8'h40;
  localparam logic [7:0]  IRQ_PCLR   = 8'h48;
  localparam logic [7:0]  BOTH_EDGE  = 8'h5C;
  // Reset values
  localparam logic [31:0] FSEL0_RST  = 32'h0000_0001;
  localparam logic [31:0] IN_CONN_RST = 32'h0000_0303;
  localparam logic [31:0] ZERO_RST   = 32'h0000_0000;
endpackage

//--- rtl/gpport_top.sv
// GPIO port pin control: registers, pad muxing and pin interrupt detection
//
// Notes on behaviour
// - Function bit 0 selects alternate, 1 I/O
// - Input and interrupts ignore function select
// - Function set alias sets written ones
// - Function clear alias clears written ones
// - Output enable drives pad; resets zero
// - Output enable set alias sets ones
// - Output enable clear alias clears ones
// - Enabled output follows output level bit
// - Level ignored when disabled or alternate
// - Output set alias sets written ones
// - Write-only output clear alias clears ones
// - Input register reads pin level where input enabled
// - Input enable gates pad; resets 0x303
// - Mode bit: 0 level, 1 edge
// - Mode and polarity need input enable
// - Level: polarity 0 low, 1 high
// - Edge: polarity 0 falling, 1 rising
// - Interrupt enable gates detection; resets zero
// - Disabling interrupt keeps pending flag
// - Interrupt enable set alias sets ones
// - Pending flags cleared by writing one
// - All pending flags share one request
// - Dual edge ignores polarity in edge mode
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ns
module gpport_top (
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  // Register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  // Pads
  input  wire logic [31:0] i_pin_in,
  output logic      [31:0] o_pin_out,
  output logic      [31:0] o_pin_oe,
  // Alternate function side
  input  wire logic [31:0] i_af_out,
  input  wire logic [31:0] i_af_oe,
  // Shared pin interrupt
  output logic             o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  logic [31:0] fsel0;
  logic [31:0] drv_en;
  logic [31:0] out_lvl;
  logic [31:0] irq_mode;
  logic [31:0] irq_pol;
  logic [31:0] in_conn;
  logic [31:0] irq_en;
  logic [31:0] both_edge;
  logic [31:0] pending;
  logic [31:0] sync_a;
  logic [31:0] sync_b;
  logic [31:0] prev_in;

  // Plain write, set alias and clear alias of one register
  function automatic logic [31:0] upd(input logic [31:0] cur,
                                      input logic        wr_plain,
                                      input logic        wr_set,
                                      input logic        wr_clr,
                                      input logic [31:0] data);
    logic [31:0] res;
    res = cur;
    if (wr_plain) begin
      res = data;
    end else if (wr_set) begin
      res = cur | data;
    end else if (wr_clr) begin
      res = cur & ~data;
    end
    return res;
  endfunction

  function automatic logic hit(input logic [7:0] off);
    return i_wr && (i_addr == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Write decode and next values

  logic [31:0] next_fsel0;
  logic [31:0] next_drv_en;
  logic [31:0] next_out_lvl;
  logic [31:0] next_irq_en;
  logic [31:0] next_irq_mode;
  logic [31:0] next_irq_pol;
  logic [31:0] next_in_conn;
  logic [31:0] next_both_edge;
  logic [31:0] pend_clr;

  // A process, not assigns: hit() reads strobe and address internally,
  // which a continuous assignment would not be sensitive to
  always_comb begin
    next_fsel0 = upd(fsel0, hit(gpport_pkg::FSEL0),
                     hit(gpport_pkg::FSEL0_SET),
                     hit(gpport_pkg::FSEL0_CLR), i_wdata);
    next_drv_en = upd(drv_en, hit(gpport_pkg::DRV_EN),
                      hit(gpport_pkg::DRV_EN_SET),
                      hit(gpport_pkg::DRV_EN_CLR), i_wdata);
    next_out_lvl = upd(out_lvl, hit(gpport_pkg::OUT_LVL),
                       hit(gpport_pkg::OUT_SET),
                       hit(gpport_pkg::OUT_CLR), i_wdata);
    next_irq_en = upd(irq_en, hit(gpport_pkg::IRQ_EN),
                      hit(gpport_pkg::IRQ_EN_SET),
                      hit(gpport_pkg::IRQ_EN_CLR), i_wdata);
    next_irq_mode  = upd(irq_mode, hit(gpport_pkg::IRQ_MODE),
                         1'b0, 1'b0, i_wdata);
    next_irq_pol   = upd(irq_pol, hit(gpport_pkg::IRQ_POL),
                         1'b0, 1'b0, i_wdata);
    next_in_conn   = upd(in_conn, hit(gpport_pkg::IN_CONN),
                         1'b0, 1'b0, i_wdata);
    next_both_edge = upd(both_edge, hit(gpport_pkg::BOTH_EDGE),
                         1'b0, 1'b0, i_wdata);
    pend_clr = hit(gpport_pkg::IRQ_PCLR) ? i_wdata : 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input path and interrupt detection

  wire logic [31:0] in_lvl;
  wire logic [31:0] rise;
  wire logic [31:0] fall;
  wire logic [31:0] lvl_hit;
  wire logic [31:0] edge_hit;
  wire logic [31:0] detect;
  wire logic [31:0] pend_set;
  wire logic [31:0] next_pending;

  // Pads are asynchronous; only sync_b is looked at
  assign in_lvl = sync_b & in_conn;
  assign rise   = sync_b & ~prev_in;
  assign fall   = ~sync_b & prev_in;
  assign lvl_hit  = irq_pol & sync_b | ~irq_pol & ~sync_b;
  assign edge_hit = both_edge & (rise | fall) |
                    ~both_edge & (irq_pol & rise | ~irq_pol & fall);
  // Function select deliberately absent from detection
  assign detect = in_conn & (irq_mode & edge_hit |
                             ~irq_mode & lvl_hit);
  assign pend_set = detect & irq_en;
  // Set beats clear; disabling leaves flags alone
  assign next_pending = (pending & ~pend_clr) | pend_set;

  ////////////////////////////////////////////////////////////////////////////
  // Pad drive

  wire logic [31:0] next_pin_oe;
  wire logic [31:0] next_pin_out;

  assign next_pin_oe  = fsel0 & drv_en | ~fsel0 & i_af_oe;
  // Level passes only where the pad is driven in I/O mode
  assign next_pin_out = fsel0 & drv_en & out_lvl |
                        ~fsel0 & i_af_out;

  ////////////////////////////////////////////////////////////////////////////
  // Read decode

  logic [31:0] rd_mux;

  always_comb begin
    if (i_addr == gpport_pkg::FSEL0) begin
      rd_mux = fsel0;
    end else if (i_addr == gpport_pkg::DRV_EN) begin
      rd_mux = drv_en;
    end else if (i_addr == gpport_pkg::OUT_LVL) begin
      rd_mux = out_lvl;
    end else if (i_addr == gpport_pkg::IN_LVL) begin
      rd_mux = in_lvl;
    end else if (i_addr == gpport_pkg::IRQ_MODE) begin
      rd_mux = irq_mode;
    end else if (i_addr == gpport_pkg::IRQ_POL) begin
      rd_mux = irq_pol;
    end else if (i_addr == gpport_pkg::IN_CONN) begin
      rd_mux = in_conn;
    end else if (i_addr == gpport_pkg::IRQ_EN) begin
      rd_mux = irq_en;
    end else if (i_addr == gpport_pkg::IRQ_PEND) begin
      rd_mux = pending;
    end else if (i_addr == gpport_pkg::BOTH_EDGE) begin
      rd_mux = both_edge;
    end else begin
      // Aliases, unmapped offsets read zero
      rd_mux = 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flip-flops

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      fsel0     <= gpport_pkg::FSEL0_RST;
      drv_en    <= gpport_pkg::ZERO_RST;
      out_lvl   <= gpport_pkg::ZERO_RST;
      irq_mode  <= gpport_pkg::ZERO_RST;
      irq_pol   <= gpport_pkg::ZERO_RST;
      in_conn   <= gpport_pkg::IN_CONN_RST;
      irq_en    <= gpport_pkg::ZERO_RST;
      both_edge <= gpport_pkg::ZERO_RST;
    end else begin
      fsel0     <= next_fsel0;
      drv_en    <= next_drv_en;
      out_lvl   <= next_out_lvl;
      irq_mode  <= next_irq_mode;
      irq_pol   <= next_irq_pol;
      in_conn   <= next_in_conn;
      irq_en    <= next_irq_en;
      both_edge <= next_both_edge;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sync_a  <= 32'h0000_0000;
      sync_b  <= 32'h0000_0000;
      prev_in <= 32'h0000_0000;
      pending <= 32'h0000_0000;
      o_irq   <= 1'b0;
    end else begin
      sync_a  <= i_pin_in;
      sync_b  <= sync_a;
      prev_in <= sync_b;
      pending <= next_pending;
      o_irq   <= |pending;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_pin_oe  <= 32'h0000_0000;
      o_pin_out <= 32'h0000_0000;
      o_rdata   <= 32'h0000_0000;
    end else begin
      o_pin_oe  <= next_pin_oe;
      o_pin_out <= next_pin_out;
      o_rdata   <= i_rd ? rd_mux : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  property p_fsel_set;
    hit(gpport_pkg::FSEL0_SET) |=> fsel0 == ($past(fsel0) | $past(i_wdata));
  endproperty
  a_fsel_set: assert property (p_fsel_set)
    else $error("function set alias wrong");

  property p_fsel_clr;
    hit(gpport_pkg::FSEL0_CLR) |=> fsel0 == ($past(fsel0) & ~$past(i_wdata));
  endproperty
  a_fsel_clr: assert property (p_fsel_clr)
    else $error("function clear alias wrong");

  property p_oe_alias;
    hit(gpport_pkg::DRV_EN_SET) |=> (drv_en & $past(i_wdata)) == $past(i_wdata)
      && (drv_en & ~$past(i_wdata)) == ($past(drv_en) & ~$past(i_wdata));
  endproperty
  a_oe_alias: assert property (p_oe_alias)
    else $error("output enable set alias wrong");

  property p_oe_clr;
    hit(gpport_pkg::DRV_EN_CLR)
      |=> drv_en == ($past(drv_en) & ~$past(i_wdata));
  endproperty
  a_oe_clr: assert property (p_oe_clr)
    else $error("output enable clear alias wrong");

  property p_out_clr;
    hit(gpport_pkg::OUT_CLR) |=> (out_lvl & $past(i_wdata)) == 32'h0000_0000;
  endproperty
  a_out_clr: assert property (p_out_clr)
    else $error("output clear alias wrong");

  property p_out_set;
    hit(gpport_pkg::OUT_SET)
      |=> out_lvl == ($past(out_lvl) | $past(i_wdata));
  endproperty
  a_out_set: assert property (p_out_set)
    else $error("output set alias wrong");

  property p_pad_drive;
    ##1 o_pin_oe == ($past(fsel0) & $past(drv_en)
                     | ~$past(fsel0) & $past(i_af_oe))
      && (o_pin_out & $past(fsel0) & ~$past(drv_en)) == 32'h0000_0000;
  endproperty
  a_pad_drive: assert property (p_pad_drive)
    else $error("pad drive mismatch");

  property p_pend_sets;
    ##1 (pending & $past(pend_set)) == $past(pend_set);
  endproperty
  a_pend_sets: assert property (p_pend_sets)
    else $error("enabled event did not set pending");

  property p_pend_clear;
    hit(gpport_pkg::IRQ_PCLR) && pend_set == 32'h0000_0000
      |=> (pending & $past(i_wdata)) == 32'h0000_0000;
  endproperty
  a_pend_clear: assert property (p_pend_clear)
    else $error("pending clear failed");

  property p_pend_hold;
    ##1 ($past(pending) & ~$past(pend_clr) & ~pending) == 32'h0000_0000;
  endproperty
  a_pend_hold: assert property (p_pend_hold)
    else $error("pending flag lost without clear");

  property p_irq;
    ##1 o_irq == |$past(pending);
  endproperty
  a_irq: assert property (p_irq)
    else $error("shared interrupt mismatch");

  property p_in_gate;
    (in_lvl & ~in_conn) == 32'h0000_0000
      && (detect & ~in_conn) == 32'h0000_0000;
  endproperty
  a_in_gate: assert property (p_in_gate)
    else $error("disconnected input visible");

  property p_dual_edge;
    (both_edge & irq_mode & in_conn & (rise | fall) & ~detect)
      == 32'h0000_0000;
  endproperty
  a_dual_edge: assert property (p_dual_edge)
    else $error("dual edge event not detected");

  property p_rd_idle;
    !i_rd |=> o_rdata == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read slot");

  c_edge_irq: cover property (hit(gpport_pkg::IRQ_EN_SET) ##[1:20] o_irq);
  c_pend_clr: cover property (o_irq ##1 hit(gpport_pkg::IRQ_PCLR) ##2 !o_irq);
  c_af_pad: cover property (fsel0 != 32'hFFFF_FFFF && o_pin_oe != 32'h0000_0000);
  c_both: cover property (|(both_edge & irq_mode & fall & in_conn & irq_en));

endmodule // gpport_top

//--- tb/tb_top.sv
// Self-checking bench for the GPIO port pin control block
`timescale 1ns/1ns
module tb_top;
  logic        clk;
  logic        rst;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic [31:0] pin_in;
  logic [31:0] pin_out;
  logic [31:0] pin_oe;
  logic [31:0] af_out;
  logic [31:0] af_oe;
  logic        irq;
  int          bad_count;
  int          checks_done;
  logic [31:0] got;
  logic [31:0] exp_v;
  logic [7:0]  off;
  logic        md;
  logic        pl;

  gpport_top DUT (
    .i_ref_clk (clk),
    .i_rst     (rst),
    .i_addr    (addr),
    .i_wdata   (wdata),
    .i_wr      (wr),
    .i_rd      (rd),
    .o_rdata   (rdata),
    .i_pin_in  (pin_in),
    .o_pin_out (pin_out),
    .o_pin_oe  (pin_oe),
    .i_af_out  (af_out),
    .i_af_oe   (af_oe),
    .o_irq     (irq)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic set_pin(input logic v);
    @(posedge clk);
    pin_in[4] <= v;
  endtask

  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Cuts a hang short; the full sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    wrap_up();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    bad_count = 0;
    checks_done = 0;
    rst = 1'b1;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    wr = 1'b0;
    rd = 1'b0;
    pin_in = 32'h0000_0000;
    af_out = 32'h0000_0000;
    af_oe = 32'h0000_0000;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    // Reset values, aliases and an unmapped offset read back
    for (int i = 0; i < 24; i++) begin
      off = 8'(i * 4);
      exp_v = (off == 8'h00) ? gpport_pkg::FSEL0_RST :
              (off == 8'h30) ? gpport_pkg::IN_CONN_RST : 32'h0000_0000;
      rd_reg(off, got);
      chk(got, exp_v);
    end
    wr_reg(8'h44, 32'hFFFF_FFFF);
    rd_reg(8'h44, got);
    chk(got, 32'h0000_0000);
    $display("test reset values done");
    // Set and clear aliases touch only bits written as one
    for (int i = 0; i < 4; i++) begin
      off = (i == 3) ? 8'h34 : 8'(i * 12);
      wr_reg(off, 32'h1234_5678);
      wr_reg(off + 8'h04, 32'h8000_0001);
      wr_reg(off + 8'h08, 32'h0000_0078);
      rd_reg(off, got);
      chk(got, 32'h9234_5601);
    end
    wr_reg(8'h34, 32'h0000_0000);
    wr_reg(8'h00, 32'hFFFF_FFFF);
    wr_reg(8'h0C, 32'h0000_0000);
    wr_reg(8'h48, 32'hFFFF_FFFF);
    $display("test aliases done");
    // Pads: level counts only where driven and in I/O mode
    wr_reg(8'h10, 32'h0000_00FF);
    wr_reg(8'h18, 32'hFF00_0F0F);
    settle(2);
    chk(pin_oe, 32'h0000_00FF);
    chk(pin_out, 32'h0000_000F);
    @(posedge clk);
    af_oe  <= 32'hFFFF_0000;
    af_out <= 32'h00F0_0000;
    wr_reg(8'h08, 32'hFFFF_0000);
    settle(2);
    chk(pin_oe, 32'hFFFF_00FF);
    chk(pin_out, 32'h00F0_000F);
    $display("test pads done");
    // Input reads follow connected pads, outputs too; the alternate pads are disconnected
    wr_reg(8'h30, 32'h0000_FFFF);
    @(posedge clk);
    pin_in <= 32'hABCD_1234;
    settle(4);
    rd_reg(8'h24, got);
    chk(got, 32'h0000_1234);
    set_pin(1'b0);
    // Every mode and polarity on pin 4
    for (int k = 0; k < 4; k++) begin
      md = k[1];
      pl = k[0];
      wr_reg(8'h34, 32'h0000_0000);
      wr_reg(8'h28, {27'd0, md, 4'h0});
      wr_reg(8'h2C, {27'd0, pl, 4'h0});
      set_pin(~pl);
      settle(4);
      wr_reg(8'h48, 32'h0000_0010);
      wr_reg(8'h38, 32'h0000_0010);
      settle(5);
      rd_reg(8'h40, got);
      chk(got, 32'h0000_0000);
      set_pin(pl);
      settle(5);
      rd_reg(8'h40, got);
      chk(got, 32'h0000_0010);
      chk({31'd0, irq}, 32'h0000_0001);
      wr_reg(8'h48, 32'h0000_0010);
      settle(5);
      rd_reg(8'h40, got);
      chk(got, md ? 32'h0000_0000 : 32'h0000_0010);
      set_pin(~pl);
      settle(4);
      wr_reg(8'h48, 32'h0000_0010);
      settle(2);
      chk({31'd0, irq}, 32'h0000_0000);
    end
    $display("test trigger modes done");
    // Flag survives disabling; only a clear removes it
    set_pin(1'b1);
    settle(5);
    rd_reg(8'h40, got);
    chk(got, 32'h0000_0010);
    wr_reg(8'h34, 32'h0000_0000);
    settle(5);
    rd_reg(8'h40, got);
    chk(got, 32'h0000_0010);
    wr_reg(8'h48, 32'h0000_0010);
    settle(5);
    rd_reg(8'h40, got);
    chk(got, 32'h0000_0000);
    // Disconnected input raises nothing, even on a qualifying edge
    wr_reg(8'h30, 32'h0000_FFEF);
    wr_reg(8'h34, 32'h0000_0010);
    set_pin(1'b0);
    set_pin(1'b1);
    settle(6);
    rd_reg(8'h40, got);
    chk(got, 32'h0000_0000);
    chk({31'd0, irq}, 32'h0000_0000);
    // Dual edge on an alternate-function pin: falling edge with polarity 1
    wr_reg(8'h30, 32'h0000_FFFF);
    wr_reg(8'h08, 32'h0000_0010);
    wr_reg(8'h5C, 32'h0000_0010);
    wr_reg(8'h48, 32'h0000_0010);
    set_pin(1'b0);
    settle(5);
    rd_reg(8'h40, got);
    chk(got, 32'h0000_0010);
    chk({31'd0, irq}, 32'h0000_0001);
    rd_reg(8'h24, got);
    chk(got, 32'h0000_1224);
    $display("test pending flags done");
    wrap_up();
  end
endmodule // tb_top
